// ==== swbm_timer.sv ====
// Supervision timer: general timer, software watchdog and bus monitor with power control.
//
// Overview of operation
// - Setting clock disable stops the down-counter; clearing it resumes counting.
// - After the lockout sequence, writes to the status register are ignored.
// - Clear location decodes the lockout sequence, enabling watchdog mode and reloading.
// - Count registers show the live counter; every reload event copies reload registers.
// - High count supplies bits 31..16, low count bits 15..0.
// - After lockout, both reload registers refuse writes until reset.
// - Lockout clears bus monitor enable and clock disable.
// - Status bit 7 is read-only watchdog active, set by lockout only.
// - Status bit 1 enables bus monitor mode and reads back.
// - Status bit 0 stops the timer clock when 1 and reads back.
// - Reload registers are 16 bits each, high and low halves.
// - A 32-bit write at high reload puts low data half high, upper half low.
// - Power bit 3 selects internal ready on a bus-monitor timeout.
// - Power bit 2 selects internal ready for halt cycles.
// - Power mode bits take effect when ready ends a halt cycle.
// - Inverted timeout output drives slave interrupt line 7.
// - At zero, timeout goes high eight clocks; counter reloads next clock.
// - In bus monitor mode, address strobe reloads and starts; ready stops.
// - Watchdog mode halts counting in core idle; other modes keep counting.
`timescale 1ns/1ps
module swbm_timer
    import swbm_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire swbm_io_req_t io_req,
    output logic [31:0]       io_rdata,
    input  wire logic         address_strobe_n,
    input  wire logic         bus_ready_n,
    input  wire logic         halt_cycle,
    input  wire logic         core_idle,
    output logic              timeout_output,
    output logic              slave_irq_line_7,
    output logic              internal_ready,
    output logic [1:0]        power_state
);

    // Pin inputs are synchronised; only the second stage is used by logic.
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    swbm_bus_evt_t evt;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_meta <= 3'h7;
            pin_sync <= 3'h7;
        end else begin
            pin_meta <= {address_strobe_n, bus_ready_n, ~halt_cycle};
            pin_sync <= pin_meta;
        end
    end

    assign evt.address_strobe = ~pin_sync[2];
    assign evt.ready          = ~pin_sync[1];
    assign evt.halt_cycle     = ~pin_sync[0];

    logic [15:0] reload_value_high;
    logic [15:0] reload_value_low;
    logic [31:0] count_bits;
    logic        watchdog_mode_active;
    logic        bus_monitor_enable;
    logic        timer_clock_disable;
    logic [7:0]  power_control;
    logic        key_armed;
    logic        bus_monitor_run;
    logic [3:0]  pulse_left;
    logic        reload_pending;

    function automatic logic hit(input swbm_io_req_t r, input logic [15:0] a);
        return r.wr && (r.addr == a);
    endfunction

    logic wr_clear;
    logic lockout;
    logic strobe_seen;
    logic count_enable;
    logic at_zero;

    assign wr_clear     = hit(io_req, SWBM_ADDR_CLEAR);
    // Second key must be the very next write of any kind, so stray writes disarm.
    // Idle cycles between the two keys are allowed, since only writes move the arming.
    assign lockout      = wr_clear && key_armed
                          && io_req.wdata[15:0] == SWBM_LOCK_KEY_SECOND;
    assign strobe_seen  = bus_monitor_enable && evt.address_strobe;
    assign count_enable = !timer_clock_disable
                          && !(watchdog_mode_active && core_idle)
                          && (power_state != SWBM_PWR_DOWN)
                          && (!bus_monitor_enable || bus_monitor_run);
    assign at_zero      = (count_bits == 32'h0000_0000);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            key_armed <= 1'b0;
        end else if (io_req.wr) begin
            key_armed <= wr_clear && io_req.wdata[15:0] == SWBM_LOCK_KEY_FIRST;
        end
    end

    // Reload registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reload_value_high <= SWBM_RST_RELOAD_HIGH;
            reload_value_low  <= SWBM_RST_RELOAD_LOW;
        end else if (!watchdog_mode_active) begin
            if (hit(io_req, SWBM_ADDR_RELOAD_HIGH)) begin
                reload_value_high <= io_req.wdata[15:0];
                if (io_req.dword) begin
                    reload_value_low <= io_req.wdata[31:16];
                end
            end else if (hit(io_req, SWBM_ADDR_RELOAD_LOW)) begin
                reload_value_low <= io_req.wdata[15:0];
            end
        end
    end

    // Status register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            watchdog_mode_active <= SWBM_RST_STATUS[SWBM_STAT_WATCHDOG_BIT];
            bus_monitor_enable   <= SWBM_RST_STATUS[SWBM_STAT_BUS_MON_BIT];
            timer_clock_disable  <= SWBM_RST_STATUS[SWBM_STAT_CLK_DIS_BIT];
        end else if (lockout) begin
            watchdog_mode_active <= 1'b1;
            bus_monitor_enable   <= 1'b0;
            timer_clock_disable  <= 1'b0;
        end else if (hit(io_req, SWBM_ADDR_STATUS) && !watchdog_mode_active) begin
            bus_monitor_enable  <= io_req.wdata[SWBM_STAT_BUS_MON_BIT];
            timer_clock_disable <= io_req.wdata[SWBM_STAT_CLK_DIS_BIT];
        end
    end

    // Power control register is never locked.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            power_control <= SWBM_RST_POWER;
        end else if (hit(io_req, SWBM_ADDR_POWER)) begin
            power_control <= {4'h0, io_req.wdata[3:0]};
        end
    end

    // Bus monitor run state: a strobe starts it, ready stops it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_monitor_run <= 1'b0;
        end else if (!bus_monitor_enable) begin
            bus_monitor_run <= 1'b0;
        end else if (evt.address_strobe) begin
            bus_monitor_run <= 1'b1;
        end else if (evt.ready) begin
            bus_monitor_run <= 1'b0;
        end
    end

    // Down-counter. A zero count reloads on the clock after it is reached.
    // Reload values below seven are not guarded here; the timeout pulse would then
    // overlap the next expiry, so software must keep to the documented minimum.
    // A pending reload is applied even while counting is frozen, so a zero count that
    // has already set reload_pending does not rest at zero across a clock disable.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_bits     <= {SWBM_RST_RELOAD_HIGH, SWBM_RST_RELOAD_LOW};
            reload_pending <= 1'b0;
        end else begin
            reload_pending <= 1'b0;
            if (lockout || strobe_seen || reload_pending) begin
                count_bits <= {reload_value_high, reload_value_low};
            end else if (count_enable) begin
                if (at_zero) begin
                    reload_pending <= 1'b1;
                end else begin
                    count_bits <= count_bits - 32'h0000_0001;
                end
            end
        end
    end

    // Timeout pulse of fixed length, with inverted copy for the interrupt unit.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulse_left       <= 4'h0;
            timeout_output   <= 1'b0;
            slave_irq_line_7 <= 1'b1;
        end else begin
            if (count_enable && at_zero && !reload_pending && !lockout && !strobe_seen) begin
                pulse_left       <= SWBM_TIMEOUT_CYCLES - 4'h1;
                timeout_output   <= 1'b1;
                slave_irq_line_7 <= 1'b0;
            end else if (pulse_left != 4'h0) begin
                pulse_left <= pulse_left - 4'h1;
            end else begin
                timeout_output   <= 1'b0;
                slave_irq_line_7 <= 1'b1;
            end
        end
    end

    // Internal ready for halt cycles and bus-monitor timeouts, and power state.
    logic timeout_ready;
    logic halt_ready;
    assign timeout_ready = power_control[SWBM_PWR_TIMEOUT_RDY] && bus_monitor_enable
                           && count_enable && at_zero && !reload_pending;
    assign halt_ready    = power_control[SWBM_PWR_HALT_RDY] && evt.halt_cycle;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            internal_ready <= 1'b0;
            power_state    <= SWBM_PWR_ACTIVE;
        end else begin
            internal_ready <= timeout_ready || halt_ready;
            if (evt.halt_cycle && (halt_ready || evt.ready)) begin
                case (power_control[SWBM_PWR_MODE_HI:SWBM_PWR_MODE_LO])
                    SWBM_PMODE_IDLE:      power_state <= SWBM_PWR_IDLE;
                    SWBM_PMODE_POWERDOWN: power_state <= SWBM_PWR_DOWN;
                    default:              power_state <= SWBM_PWR_ACTIVE;
                endcase
            end
        end
    end

    // Read data, registered; reserved bits read as zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            io_rdata <= 32'h0000_0000;
        end else if (io_req.rd) begin
            case (io_req.addr)
                SWBM_ADDR_RELOAD_HIGH: io_rdata <= {reload_value_low, reload_value_high};
                SWBM_ADDR_RELOAD_LOW:  io_rdata <= {16'h0000, reload_value_low};
                SWBM_ADDR_COUNT_HIGH:  io_rdata <= {count_bits[15:0], count_bits[31:16]};
                SWBM_ADDR_COUNT_LOW:   io_rdata <= {16'h0000, count_bits[15:0]};
                SWBM_ADDR_STATUS:      io_rdata <= {24'h00_0000, watchdog_mode_active,
                                                    5'h00, bus_monitor_enable,
                                                    timer_clock_disable};
                SWBM_ADDR_POWER:       io_rdata <= {24'h00_0000, power_control};
                default:               io_rdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// ==== swbm_pkg.sv ====
// Package with register map, field layout, reset values and timing of the supervision timer.
package swbm_pkg;

    localparam logic [15:0] SWBM_ADDR_RELOAD_HIGH = 16'hF4C0;
    localparam logic [15:0] SWBM_ADDR_RELOAD_LOW  = 16'hF4C2;
    localparam logic [15:0] SWBM_ADDR_COUNT_HIGH  = 16'hF4C4;
    localparam logic [15:0] SWBM_ADDR_COUNT_LOW   = 16'hF4C6;
    localparam logic [15:0] SWBM_ADDR_CLEAR       = 16'hF4C8;
    localparam logic [15:0] SWBM_ADDR_STATUS      = 16'hF4CA;
    localparam logic [15:0] SWBM_ADDR_POWER       = 16'hF800;

    localparam logic [15:0] SWBM_RST_RELOAD_HIGH  = 16'h003F;
    localparam logic [15:0] SWBM_RST_RELOAD_LOW   = 16'hFFFF;
    localparam logic [7:0]  SWBM_RST_STATUS       = 8'h00;
    localparam logic [7:0]  SWBM_RST_POWER        = 8'h00;

    localparam logic [15:0] SWBM_LOCK_KEY_FIRST   = 16'hF01E;
    localparam logic [15:0] SWBM_LOCK_KEY_SECOND  = 16'h0FE1;

    localparam int SWBM_STAT_WATCHDOG_BIT  = 7;
    localparam int SWBM_STAT_BUS_MON_BIT   = 1;
    localparam int SWBM_STAT_CLK_DIS_BIT   = 0;
    localparam int SWBM_PWR_TIMEOUT_RDY    = 3;
    localparam int SWBM_PWR_HALT_RDY       = 2;
    localparam int SWBM_PWR_MODE_HI        = 1;
    localparam int SWBM_PWR_MODE_LO        = 0;

    localparam logic [1:0] SWBM_PMODE_IDLE      = 2'h1;
    localparam logic [1:0] SWBM_PMODE_POWERDOWN = 2'h2;

    // Timeout pulse lasts eight processor clocks.
    localparam int         SWBM_TIMEOUT_CLOCKS  = 8;
    localparam logic [3:0] SWBM_TIMEOUT_CYCLES  = 4'(SWBM_TIMEOUT_CLOCKS);

    typedef enum logic [1:0] {
        SWBM_PWR_ACTIVE,
        SWBM_PWR_IDLE,
        SWBM_PWR_DOWN
    } swbm_power_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        dword;
        logic [15:0] addr;
        logic [31:0] wdata;
    } swbm_io_req_t;

    typedef struct packed {
        logic address_strobe;
        logic ready;
        logic halt_cycle;
    } swbm_bus_evt_t;

endpackage

// ==== swbm_timer_props.sv ====
// Checker on the ports of the supervision timer, bound into the design.
`timescale 1ns/1ps
module swbm_timer_props
    import swbm_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         rst,
    input wire swbm_io_req_t io_req,
    input wire logic [31:0]  io_rdata,
    input wire logic         halt_cycle,
    input wire logic         timeout_output,
    input wire logic         slave_irq_line_7,
    input wire logic         internal_ready,
    input wire logic [1:0]   power_state
);
    logic [7:0] pwr;
    logic       rd_stat;
    logic       seen_wd;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // The power register stays writable after lockout, so a plain shadow is exact for bits 3..0.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) pwr <= 8'h00;
        else if (io_req.wr && io_req.addr == SWBM_ADDR_POWER) pwr <= io_req.wdata[7:0];
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) rd_stat <= 1'b0;
        else rd_stat <= io_req.rd && io_req.addr == SWBM_ADDR_STATUS;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) seen_wd <= 1'b0;
        else if (rd_stat && io_rdata[7]) seen_wd <= 1'b1;
    end
    a_irq_inverse: assert property (slave_irq_line_7 == !timeout_output)
        else $error("irq line is not the inverse of timeout");
    a_pulse_width: assert property ($rose(timeout_output) |-> timeout_output [*8] ##1 !timeout_output)
        else $error("timeout pulse is not eight clocks");
    a_wd_sticky: assert property (rd_stat && seen_wd |-> io_rdata[7])
        else $error("watchdog active bit cleared without reset");
    a_halt_ready: assert property ($rose(halt_cycle) && pwr[2] |-> ##[1:6] internal_ready)
        else $error("no internal ready for halt cycle");
    a_no_ready: assert property (pwr[3:2] == 2'h0 && $past(pwr[3:2]) == 2'h0 |-> !internal_ready)
        else $error("internal ready while both ready bits clear");
    a_idle_entry: assert property ($rose(halt_cycle) && pwr[2] && pwr[1:0] == 2'h1
        |-> ##[1:8] power_state == 2'h1)
        else $error("idle mode not entered after halt");
    a_mode_cause: assert property ($changed(power_state) |-> $past(pwr[1]) != $past(pwr[0]))
        else $error("power state changed with equal mode bits");
    a_low_stay: assert property (power_state != 2'h0 |=> $stable(power_state))
        else $error("low power state left without reset");
    c_timeout: cover property ($rose(timeout_output));
    c_powerdown: cover property (power_state == 2'h2);
    c_watchdog: cover property (rd_stat && io_rdata[7]);
endmodule

bind swbm_timer swbm_timer_props u_props (.ref_clk, .rst, .io_req, .io_rdata, .halt_cycle,
    .timeout_output, .slave_irq_line_7, .internal_ready, .power_state);

// ==== swbm_bus_model.sv ====
// Behavioural model of the core bus unit: strobe, ready, halt and idle.
`timescale 1ns/1ps
module swbm_bus_model (
    input  wire logic ref_clk,
    input  wire logic internal_ready,
    output logic      address_strobe_n,
    output logic      bus_ready_n,
    output logic      halt_cycle,
    output logic      core_idle
);
    initial begin
        address_strobe_n = 1'b1;
        bus_ready_n = 1'b1;
        halt_cycle = 1'b0;
        core_idle = 1'b0;
    end
    // A cycle ends after w clocks, or early once the timer makes ready itself.
    task automatic bus_cycle(input int w);
        @(negedge ref_clk) address_strobe_n = 1'b0;
        @(negedge ref_clk) address_strobe_n = 1'b1;
        for (int i = 0; i < w && internal_ready !== 1'b1; i++) @(negedge ref_clk);
        bus_ready_n = 1'b0;
        @(negedge ref_clk) bus_ready_n = 1'b1;
    endtask
    task automatic halt(input bit ext);
        @(negedge ref_clk) halt_cycle = 1'b1;
        for (int i = 0; i < 6 && internal_ready !== 1'b1; i++) @(negedge ref_clk);
        if (ext) bus_ready_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        halt_cycle = 1'b0;
        bus_ready_n = 1'b1;
    endtask
    task automatic set_idle(input bit v);
        @(negedge ref_clk) core_idle = v;
    endtask
endmodule

// ==== swbm_timer_bench.sv ====
// Testbench for the supervision timer: register tasks, bus model and timeout counts.
`timescale 1ns/1ps
module swbm_timer_bench
    import swbm_pkg::*;
;
    logic         ref_clk, rst, timeout_output, slave_irq_line_7, internal_ready;
    logic         address_strobe_n, bus_ready_n, halt_cycle, core_idle;
    logic [1:0]   power_state;
    logic [31:0]  io_rdata, a, b;
    swbm_io_req_t io_req;
    int           fails = 0, tests_run = 0, tout_cnt = 0, rdy_cnt = 0, c0, c1;
    logic [15:0]  ra[6] = '{16'hF4C0, 16'hF4C2, 16'hF4C4, 16'hF4CA, 16'hF800, 16'hF4CC};
    logic [15:0]  rv[6] = '{16'h003F, 16'hFFFF, 16'h003F, 16'h0000, 16'h0000, 16'h0000};
    logic [7:0]   pv[4] = '{8'h05, 8'h06, 8'h07, 8'h01};
    logic [1:0]   ps[4] = '{2'h1, 2'h2, 2'h0, 2'h1};
    swbm_timer dut (.ref_clk, .rst, .io_req, .io_rdata, .address_strobe_n, .bus_ready_n,
        .halt_cycle, .core_idle, .timeout_output, .slave_irq_line_7, .internal_ready, .power_state);
    swbm_bus_model bm (.ref_clk, .internal_ready, .address_strobe_n, .bus_ready_n, .halt_cycle,
        .core_idle);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        tout_cnt += (timeout_output === 1'b1);
        rdy_cnt += (internal_ready === 1'b1);
    end
    task automatic check(input logic [31:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [15:0] ad, input logic [31:0] d, input logic dw = 1'b0);
        @(negedge ref_clk) io_req = '{1'b0, 1'b1, dw, ad, d};
        @(negedge ref_clk) io_req = '0;
    endtask
    task automatic rd(input logic [15:0] ad, output logic [31:0] d, input logic dw = 1'b0);
        @(negedge ref_clk) io_req = '{1'b1, 1'b0, dw, ad, 32'h0};
        @(negedge ref_clk) io_req = '0;
        d = io_rdata;
    endtask
    task automatic rchk(input logic [15:0] ad, e, input string w);
        logic [31:0] v;
        rd(ad, v);
        check({16'h0, v[15:0]}, {16'h0, e}, w);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
    endtask
    initial begin
        io_req = '0;
        do_reset;
        for (int i = 0; i < 6; i++) rchk(ra[i], rv[i], "reset value");
        rd(SWBM_ADDR_RELOAD_HIGH, a, 1'b1);
        check(a, 32'hFFFF003F, "dword reload");
        wr(SWBM_ADDR_RELOAD_HIGH, 32'h000A0000, 1'b1);
        rchk(SWBM_ADDR_RELOAD_HIGH, 16'h0000, "reload high");
        rchk(SWBM_ADDR_RELOAD_LOW, 16'h000A, "reload low");
        wr(SWBM_ADDR_STATUS, 32'h02);
        rchk(SWBM_ADDR_STATUS, 16'h0002, "bus monitor bit");
        wr(SWBM_ADDR_POWER, 32'h08);
        c0 = tout_cnt;
        c1 = rdy_cnt;
        bm.bus_cycle(60);
        repeat (12) @(negedge ref_clk);
        check(32'(tout_cnt - c0), 32'd8, "bus timeout clocks");
        check(32'(rdy_cnt > c1), 32'd1, "timeout ready");
        c0 = tout_cnt;
        bm.bus_cycle(3);
        repeat (20) @(negedge ref_clk);
        check(32'(tout_cnt - c0), 32'd0, "short cycle timeout");
        wr(SWBM_ADDR_STATUS, 32'h00);
        c0 = tout_cnt;
        repeat (40) @(negedge ref_clk);
        check(32'(tout_cnt - c0 >= 16), 32'd1, "free running timeouts");
        rd(SWBM_ADDR_COUNT_LOW, a);
        check(32'(a[15:0] <= 16'h000A), 32'd1, "live count");
        wr(SWBM_ADDR_STATUS, 32'h01);
        rchk(SWBM_ADDR_STATUS, 16'h0001, "clock disable bit");
        rd(SWBM_ADDR_COUNT_LOW, a);
        rd(SWBM_ADDR_COUNT_LOW, b);
        check(b, a, "stopped count");
        // A write between the two keys must disarm the first one.
        wr(SWBM_ADDR_CLEAR, 32'(SWBM_LOCK_KEY_FIRST));
        wr(SWBM_ADDR_POWER, 32'h00);
        wr(SWBM_ADDR_CLEAR, 32'(SWBM_LOCK_KEY_SECOND));
        rchk(SWBM_ADDR_STATUS, 16'h0001, "disarmed key");
        wr(SWBM_ADDR_CLEAR, 32'(SWBM_LOCK_KEY_FIRST));
        wr(SWBM_ADDR_CLEAR, 32'(SWBM_LOCK_KEY_SECOND));
        rchk(SWBM_ADDR_STATUS, 16'h0080, "lockout status");
        wr(SWBM_ADDR_STATUS, 32'h03);
        rchk(SWBM_ADDR_STATUS, 16'h0080, "locked status");
        wr(SWBM_ADDR_RELOAD_HIGH, 32'h1234);
        rchk(SWBM_ADDR_RELOAD_HIGH, 16'h0000, "locked reload");
        rd(SWBM_ADDR_COUNT_LOW, a);
        rd(SWBM_ADDR_COUNT_LOW, b);
        check(32'(a !== b), 32'd1, "count after lockout");
        bm.set_idle(1'b1);
        rd(SWBM_ADDR_COUNT_LOW, a);
        rd(SWBM_ADDR_COUNT_LOW, b);
        check(b, a, "idle watchdog count");
        bm.set_idle(1'b0);
        for (int i = 0; i < 4; i++) begin
            do_reset;
            wr(SWBM_ADDR_POWER, 32'(pv[i]));
            c1 = rdy_cnt;
            bm.halt(i == 3);
            check(32'(power_state), 32'(ps[i]), "power state");
            check(32'(rdy_cnt > c1), 32'(i != 3), "halt ready");
        end
        print_verdict;
    end
    initial begin
        #500000;
        fails++;
        print_verdict;
    end
endmodule
